/* rtl/sac_top.sv */
// converter control top: AXI4-Lite registers, trigger, scan and threshold
// assumes an external sample/hold, tap ladder and comparator driven by these pins
`timescale 1ns/1ps
`default_nettype none
module sac_top import sac_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_pin,
  input wire logic timer_compare_event,
  input wire logic cmp_ge,
  output logic [2:0] analog_ch_q,
  output logic sample_q,
  output logic [RES_W-1:0] tap_q,
  output logic conversion_end_irq_q,
  output logic reference_gen_enable_q
);
  if (SAMPLE_CYCLES < 1 || STEP_CYCLES < 1) begin : g_chk
    $error("timing counts must be at least one");
  end
  // ==========================================================
  // register addresses
  localparam logic [AW-1:0] A_MODE = sac_addr(IDX_MODE);
  localparam logic [AW-1:0] A_CHSEL = sac_addr(IDX_CHSEL);
  localparam logic [AW-1:0] A_RES = sac_addr(IDX_RES);
  localparam logic [AW-1:0] A_RESH = sac_addr(IDX_RESH);
  localparam logic [AW-1:0] A_PFM = sac_addr(IDX_PFM);
  localparam logic [AW-1:0] A_PFT = sac_addr(IDX_PFT);
  localparam logic [AW-1:0] A_STAT = sac_addr(IDX_STAT);

  sac_mode_t mode_q;
  sac_chsel_t chsel_q;
  sac_pfm_t pfm_q;
  logic [7:0] pft_q;
  logic [RES_W-1:0] res_q;
  sac_ctl_st_t st_q, st_d;
  logic [2:0] ch_d;
  logic start_c, abort_c;
  logic hw_trig, core_done, core_busy;

  // ==========================================================
  // AXI4-Lite write channel
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic [AW-1:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wstb_q;
  logic [1:0] bresp_q;
  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  // address and data may arrive in either order
  wire wr_go = (aw_full_q | aw_hs) & (w_full_q | w_hs) & ~bvalid_q;
  wire [AW-1:0] wa = aw_hs ? s_axi_awaddr : waddr_q;
  wire [7:0] wd = w_hs ? s_axi_wdata[7:0] : wbyte_q;
  wire ws = w_hs ? s_axi_wstrb[0] : wstb_q;
  wire wsel_mode = wa == A_MODE;
  wire wsel_chsel = wa == A_CHSEL;
  wire wsel_pfm = wa == A_PFM;
  wire wsel_pft = wa == A_PFT;
  wire wr_known = wsel_mode | wsel_chsel | wsel_pfm | wsel_pft;
  wire ctl_wr = wr_go & wr_known;
  wire aw_full_d = (aw_full_q | aw_hs) & ~wr_go;
  wire w_full_d = (w_full_q | w_hs) & ~wr_go;
  wire bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);

  // handshake state; readies drop while a half or a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (wr_go) bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // holding registers for whichever half came first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wstb_q <= 1'b0;
    end else if (ce) begin
      if (aw_hs) waddr_q <= s_axi_awaddr;
      if (w_hs) wbyte_q <= s_axi_wdata[7:0];
      if (w_hs) wstb_q <= s_axi_wstrb[0];
    end
  end

  // control registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= sac_mode_t'(RST_MODE);
      chsel_q <= sac_chsel_t'(RST_CHSEL);
      pfm_q <= sac_pfm_t'(RST_PFM);
      pft_q <= RST_PFT;
    end else if (ce && wr_go && ws) begin
      if (wsel_mode) mode_q <= sac_mode_t'(wd & MODE_WMASK);
      if (wsel_chsel) chsel_q <= sac_chsel_t'(wd & CHSEL_WMASK);
      if (wsel_pfm) pfm_q <= sac_pfm_t'(wd & PFM_WMASK);
      if (wsel_pft) pft_q <= wd;
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign reference_gen_enable_q = mode_q.reference_gen_enable;

  // ==========================================================
  // AXI4-Lite read channel
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_hs = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
  wire [AW-1:0] ra = s_axi_araddr;
  wire [7:0] stat_w = {st_q == ST_CONV, st_q == ST_WAIT, 3'h0, analog_ch_q};
  wire rd_known = (ra == A_MODE) | (ra == A_CHSEL) | (ra == A_RES) | (ra == A_RESH)
                | (ra == A_PFM) | (ra == A_PFT) | (ra == A_STAT);
  // result reads left-justified; high view is the top eight bits
  wire [31:0] rd_word =
      (ra == A_MODE) ? {24'h000000, mode_q} :
      (ra == A_CHSEL) ? {24'h000000, chsel_q} :
      (ra == A_RES) ? {16'h0000, res_q, 6'h00} :
      (ra == A_RESH) ? {24'h000000, res_q[9:2]} :
      (ra == A_PFM) ? {24'h000000, pfm_q} :
      (ra == A_PFT) ? {24'h000000, pft_q} :
      (ra == A_STAT) ? {24'h000000, stat_w} : 32'h00000000;

  // one read in flight; data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_hs) rdata_q <= rd_word;
      if (ar_hs) rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
  end
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // conversion control
  wire conv_en = mode_q.conversion_enable;
  wire hs = (mode_q.speed_sel == SPD_HS_A) | (mode_q.speed_sel == SPD_HS_B);
  wire hw_mode = chsel_q.trigger_source_sel;
  // select mode stays on channel n; scan runs 0..n and wraps
  wire [2:0] first_ch = mode_q.scan_mode ? 3'h0 : chsel_q.channel_code;
  wire [2:0] next_ch = !mode_q.scan_mode ? chsel_q.channel_code :
                       (analog_ch_q == chsel_q.channel_code) ? 3'h0 : analog_ch_q + 3'h1;
  // a control write in normal speed is the software's fault and aborts nothing
  wire hs_wr = hs & ctl_wr;
  wire fin = (st_q == ST_CONV) & core_done & conv_en & ~hs_wr;
  wire pass = sac_cmp_pass(pfm_q, tap_q[9:2], pft_q);

  // state selection; abandon and abort outrank completion
  always_comb begin
    st_d = st_q;
    ch_d = analog_ch_q;
    start_c = 1'b0;
    abort_c = 1'b0;
    unique case (st_q)
      ST_OFF: if (conv_en) begin
        ch_d = first_ch;
        if (hw_mode) begin
          st_d = ST_WAIT;
        end else begin
          st_d = ST_CONV;
          start_c = 1'b1;
        end
      end
      ST_WAIT: if (!conv_en) begin
        st_d = ST_OFF;
      end else if (hw_trig) begin
        st_d = ST_CONV;
        start_c = 1'b1;
      end
      ST_CONV: if (!conv_en) begin
        st_d = ST_OFF;
        abort_c = 1'b1;
      end else if (hs_wr) begin
        // re-entry through the off state picks up the new settings
        st_d = ST_OFF;
        abort_c = 1'b1;
      end else if (core_done) begin
        ch_d = next_ch;
        if (!hw_mode || hw_trig) begin
          start_c = 1'b1;
        end else begin
          st_d = ST_WAIT;
        end
      end else if (hs && hw_trig) begin
        ch_d = first_ch;
        start_c = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_OFF;
      analog_ch_q <= 3'h0;
    end else if (ce) begin
      st_q <= st_d;
      analog_ch_q <= ch_d;
    end
  end

  // result latch and threshold-gated end event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= '0;
      conversion_end_irq_q <= 1'b0;
    end else if (ce) begin
      if (fin) res_q <= tap_q;
      conversion_end_irq_q <= fin & pass;
    end
  end

  // ==========================================================
  // submodules
  sac_trig_det u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(external_trigger_pin),
    .timer_evt(timer_compare_event),
    .cs(chsel_q),
    .armed(conv_en),
    .trig_q(hw_trig)
  );

  sac_sar_core #(.SAMP(SAMPLE_CYCLES), .STEP(STEP_CYCLES)) u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(start_c),
    .abort(abort_c),
    .cmp_ge(cmp_ge),
    .sample_q(sample_q),
    .tap_q(tap_q),
    .done_q(core_done),
    .busy_q(core_busy)
  );

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  property p_sw_start;
    (st_q == ST_OFF && conv_en && !hw_mode) |=> (st_q == ST_CONV && sample_q);
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missed");

  property p_hw_wait;
    (st_q == ST_OFF && conv_en && hw_mode) |=> (st_q == ST_WAIT && !sample_q);
  endproperty
  a_hw_wait: assert property (p_hw_wait) else $error("hardware mode did not wait");

  property p_res_read;
    (ar_hs && ra == A_RES) |=> (rdata_q[5:0] == 6'h00 && rdata_q[15:6] == $past(res_q));
  endproperty
  a_res_read: assert property (p_res_read) else $error("result read wrong");

  property p_resh_read;
    (ar_hs && ra == A_RESH) |=> (rdata_q == {24'h000000, $past(res_q[9:2])});
  endproperty
  a_resh_read: assert property (p_resh_read) else $error("high view read wrong");

  property p_no_cmp;
    (fin && !pfm_q.threshold_compare_enable) |=> conversion_end_irq_q;
  endproperty
  a_no_cmp: assert property (p_no_cmp) else $error("end event missing");

  property p_cmp_dir;
    (fin && pfm_q.threshold_compare_enable) |=> (conversion_end_irq_q ==
      (pfm_q.compare_direction ? (res_q[9:2] < pft_q) : (res_q[9:2] >= pft_q)));
  endproperty
  a_cmp_dir: assert property (p_cmp_dir) else $error("threshold gate wrong");

  property p_irq_cause;
    conversion_end_irq_q |-> $past(fin);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray end event");

  property p_abandon;
    (st_q == ST_CONV && !conv_en) |=> (st_q == ST_OFF && !conversion_end_irq_q) ##1 !core_busy;
  endproperty
  a_abandon: assert property (p_abandon) else $error("abandon failed");

  property p_hs_wr_abort;
    (st_q == ST_CONV && conv_en && hs_wr) |=> (st_q == ST_OFF && !core_busy);
  endproperty
  a_hs_wr_abort: assert property (p_hs_wr_abort) else $error("write abort failed");

  property p_hs_restart;
    (st_q == ST_CONV && conv_en && !hs_wr && !core_done && hs && hw_trig)
      |=> (sample_q && analog_ch_q == $past(first_ch));
  endproperty
  a_hs_restart: assert property (p_hs_restart) else $error("trigger restart failed");

  property p_back_to_back;
    (fin && !hw_mode) |=> (sample_q && analog_ch_q == $past(next_ch));
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("no repeat conversion");

  c_irq: cover property (conversion_end_irq_q);
  c_scan_wrap: cover property (fin && mode_q.scan_mode && next_ch == 3'h0 && analog_ch_q != 3'h0);
  c_hs_restart: cover property (st_q == ST_CONV && hs && hw_trig && !core_done);
endmodule
`default_nettype wire

/* common/sac_pkg.sv */
// shared constants and types of the converter control block
// assumes a 200 MHz aclk and an AXI4-Lite register slave with 12 address bits
package sac_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 5;
  localparam int SAMPLE_NS = 100;
  localparam int STEP_NS = 20;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // sizes and register indices (byte address is four times the index)
  localparam int RES_W = 10;
  localparam int AW = 12;
  localparam logic [31:0] IDX_MODE = 32'hFFFFF200;
  localparam logic [31:0] IDX_CHSEL = 32'hFFFFF201;
  localparam logic [31:0] IDX_RES = 32'hFFFFF202;
  localparam logic [31:0] IDX_RESH = 32'hFFFFF203;
  localparam logic [31:0] IDX_PFM = 32'hFFFFF204;
  localparam logic [31:0] IDX_PFT = 32'hFFFFF205;
  localparam logic [31:0] IDX_STAT = 32'hFFFFF206;
  // ==========================================================
  // reset values, write masks, codes
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CHSEL = 8'h00;
  localparam logic [7:0] RST_PFM = 8'h00;
  localparam logic [7:0] RST_PFT = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hF8;
  localparam logic [7:0] CHSEL_WMASK = 8'hF7;
  localparam logic [7:0] PFM_WMASK = 8'hC0;
  localparam logic [1:0] SPD_HS_A = 2'h1;
  localparam logic [1:0] SPD_HS_B = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // register layouts
  typedef struct packed {
    logic conversion_enable;
    logic reference_gen_enable;
    logic [1:0] speed_sel;
    logic scan_mode;
    logic [2:0] rsv;
  } sac_mode_t;
  typedef struct packed {
    logic edge_sel_hi;
    logic edge_sel_lo;
    logic trigger_source_sel;
    logic hw_source_sel;
    logic rsv;
    logic [2:0] channel_code;
  } sac_chsel_t;
  typedef struct packed {
    logic threshold_compare_enable;
    logic compare_direction;
    logic [5:0] rsv;
  } sac_pfm_t;
  typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_CONV} sac_ctl_st_t;
  typedef enum logic [1:0] {CS_IDLE, CS_SAMP, CS_BIT} sac_core_st_t;
  // ==========================================================
  // helpers
  function automatic logic [AW-1:0] sac_addr(input logic [31:0] idx);
    return {idx[AW-3:0], 2'h0};
  endfunction
  function automatic logic sac_cmp_pass(input sac_pfm_t m, input logic [7:0] hi,
                                        input logic [7:0] thr);
    return !m.threshold_compare_enable || (m.compare_direction ? (hi < thr) : (hi >= thr));
  endfunction
endpackage

/* rtl/sac_trig_det.sv */
// hardware trigger detection: external pin edge or timer event
// assumes pin and timer event are synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module sac_trig_det import sac_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin,
  input wire logic timer_evt,
  input wire sac_chsel_t cs,
  input wire logic armed,
  output logic trig_q
);
  // ==========================================================
  // edge and source selection
  logic pin_q;
  wire rise = pin & ~pin_q;
  wire fall = ~pin & pin_q;
  // hi bit picks rising, lo bit falling, both for either, none for 00
  wire edge_hit = (cs.edge_sel_hi & rise) | (cs.edge_sel_lo & fall);
  wire src_hit = cs.hw_source_sel ? timer_evt : edge_hit;
  // source bits only count in hardware trigger operation
  wire hit = armed & cs.trigger_source_sel & src_hit;

  // pin history and registered trigger pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (ce) begin
      pin_q <= pin;
      trig_q <= hit;
    end
  end
endmodule
`default_nettype wire

/* rtl/sac_sar_core.sv */
// successive approximation sequencer: sample, hold, ten trial bits
// assumes an analog comparator answers cmp_ge within STEP cycles of a tap change
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core import sac_pkg::*; #(
  parameter int SAMP = SAMPLE_CYC,
  parameter int STEP = STEP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_ge,
  output logic sample_q,
  output logic [RES_W-1:0] tap_q,
  output logic done_q,
  output logic busy_q
);
  localparam int CW = $clog2((SAMP > STEP ? SAMP : STEP) + 1);
  if (SAMP < 1 || STEP < 1) begin : g_chk
    $error("sample and step counts must be at least one");
  end
  // ==========================================================
  // trial bit helper
  function automatic logic [RES_W-1:0] bitmask(input logic [3:0] b);
    return RES_W'(1) << b;
  endfunction

  sac_core_st_t st_q;
  logic [CW-1:0] cnt_q;
  logic [3:0] bit_q;
  wire [RES_W-1:0] decided = cmp_ge ? tap_q : (tap_q & ~bitmask(bit_q));

  // abort beats start; start while busy restarts from sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CS_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      tap_q <= '0;
      sample_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (abort) begin
        st_q <= CS_IDLE;
        sample_q <= 1'b0;
      end else if (start) begin
        st_q <= CS_SAMP;
        sample_q <= 1'b1;
        cnt_q <= CW'(SAMP - 1);
      end else begin
        unique case (st_q)
          CS_IDLE: ;
          CS_SAMP: if (cnt_q == '0) begin
            sample_q <= 1'b0;
            tap_q <= bitmask(4'h9);
            bit_q <= 4'h9;
            cnt_q <= CW'(STEP - 1);
            st_q <= CS_BIT;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
          CS_BIT: if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (bit_q == 4'h0) begin
            tap_q <= decided;
            done_q <= 1'b1;
            st_q <= CS_IDLE;
          end else begin
            tap_q <= decided | bitmask(bit_q - 4'h1);
            bit_q <= bit_q - 4'h1;
            cnt_q <= CW'(STEP - 1);
          end
        endcase
      end
    end
  end
  assign busy_q = (st_q != CS_IDLE);
endmodule
`default_nettype wire

/* verif/sac_afe_model.sv */
// analog front end stand-in: channel levels, sample/hold, comparator
// assumes the bench sets eight 10-bit levels packed in lvl
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model (
  input wire logic aclk,
  input wire logic [2:0] ch,
  input wire logic sample,
  input wire logic [9:0] tap,
  input wire logic [79:0] lvl,
  output logic cmp_ge
);
  // ==========================================
  // held level follows the input only while sampling
  logic [9:0] held_q;
  always_ff @(posedge aclk) begin
    if (sample) begin
      held_q <= lvl[ch*10 +: 10];
    end
  end
  assign cmp_ge = held_q >= tap;
endmodule
`default_nettype wire

/* verif/sar_adc_trigger_threshold_ctrl_tb.sv */
// bench for the converter control top with a front end stand-in
// assumes short sample and step counts; registers via AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module sar_adc_trigger_threshold_ctrl_tb import sac_pkg::*;;
  logic aclk = 0, aresetn = 0, pin = 0, tmr = 0, g;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cmp_ge, smp, irq, refen;
  logic [1:0] bresp, rresp;
  logic [2:0] ch;
  logic [9:0] tap;
  logic [79:0] lvl = 0;
  logic [15:0] lf = 16'h4953;
  logic [7:0] hi, thr, pm, cs;
  logic [9:0] exp_q[$], exp_res;
  int errors = 0, checks_done = 0, k;
  // ==========================================
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  sac_top #(.SAMPLE_CYCLES(2), .STEP_CYCLES(1)) i_sac_top (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_trigger_pin(pin), .timer_compare_event(tmr), .cmp_ge(cmp_ge),
    .analog_ch_q(ch), .sample_q(smp), .tap_q(tap), .conversion_end_irq_q(irq),
    .reference_gen_enable_q(refen));
  sac_afe_model i_sac_afe_model (.aclk(aclk), .ch(ch), .sample(smp), .tap(tap), .lvl(lvl),
    .cmp_ge(cmp_ge));
  // ==========================================
  // next pseudo-random state, shared by every random level
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a bus wait that runs dry ends the run
  task automatic tmo(input int t);
    if (t >= 40) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    tmo(t);
    chk(bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    tmo(t);
    chk(rdata, exp);
    chk(rresp, er);
  endtask
  // bounded look for the end pulse; running out is a legal outcome here
  task automatic wirq(input int lim, output logic got);
    int t;
    got = 0;
    for (t = 0; t < lim; t++) begin
      @(posedge aclk);
      if (irq === 1'b1) begin
        got = 1;
        break;
      end
    end
  endtask
  // ==========================================
  initial begin
    for (k = 0; k < 8; k++) begin
      lf = lfsr_next(lf);
      lvl[k*10 +: 10] = lf[9:0];
    end
    hi = lvl[59:52];
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(12'h804, 0, 0);
    rd(12'h810, 0, 0);
    rd(12'h814, 0, 0);
    rd(12'hFFC, 0, 2'h2);
    wr(12'h808, 8'h12, 2'h2);
    // reference first, then the longer normal-speed settle before any enable
    wr(12'h800, 8'h40, 0);
    repeat (2800) @(posedge aclk);
    chk(refen, 1);
    $display("registers done");
    // software trigger, select channel 5, runs back to back; bit 3 kept zero
    wr(12'h804, 8'h05, 0);
    wr(12'h800, 8'hC0, 0);
    repeat (2) begin
      wirq(40, g);
      chk(g, 1);
      rd(12'h808, {16'h0, lvl[59:50], 6'h0}, 0);
      rd(12'h80C, {24'h0, hi}, 0);
    end
    // stopping keeps the reference up, so no second settle is due
    wr(12'h800, 8'h40, 0);
    // scan over inputs 0..2; settings only change while stopped
    for (k = 0; k < 4; k++) begin
      exp_q.push_back(lvl[(k%3)*10 +: 10]);
    end
    wr(12'h804, 8'h02, 0);
    wr(12'h800, 8'hC8, 0);
    while (exp_q.size() > 0) begin
      exp_res = exp_q.pop_front();
      wirq(40, g);
      chk(g, 1);
      rd(12'h808, {16'h0, exp_res, 6'h0}, 0);
    end
    wr(12'h800, 8'h40, 0);
    $display("software trigger done");
    // threshold gating at the boundary, both directions
    for (k = 0; k < 6; k++) begin
      thr = hi + 8'(k % 2);
      pm = (k < 2) ? 8'h00 : (k < 4) ? 8'h80 : 8'hC0;
      wr(12'h810, pm, 0);
      wr(12'h814, thr, 0);
      wr(12'h804, 8'h05, 0);
      wr(12'h800, 8'hC0, 0);
      wirq(40, g);
      chk(g, !pm[7] || (pm[6] ? hi < thr : hi >= thr));
      wr(12'h800, 8'h40, 0);
    end
    // clearing enable mid conversion leaves no end pulse
    wr(12'h810, 8'h00, 0);
    wr(12'h800, 8'hC0, 0);
    repeat (3) @(posedge aclk);
    wr(12'h800, 8'h40, 0);
    wirq(40, g);
    chk(g, 0);
    // high speed: a threshold write mid conversion aborts and restarts it
    wr(12'h800, 8'hD0, 0);
    repeat (5) @(posedge aclk);
    wr(12'h814, 8'h00, 0);
    wirq(8, g);
    chk(g, 0);
    wirq(10, g);
    chk(g, 1);
    wr(12'h800, 8'h40, 0);
    $display("threshold done");
    // hardware trigger: four edge codes on the pin, then the timer
    for (k = 0; k < 5; k++) begin
      cs = (k < 4) ? {k[1:0], 6'h25} : 8'h35;
      wr(12'h804, cs, 0);
      // high speed only, so a second trigger mid conversion stays legal
      wr(12'h800, 8'hD0, 0);
      wirq(30, g);
      chk(g, 0);
      pin <= 1;
      tmr <= (k == 4);
      @(posedge aclk);
      tmr <= 0;
      wirq(30, g);
      chk(g, k >= 2);
      pin <= 0;
      wirq(30, g);
      chk(g, k[0] && k < 4);
      wr(12'h800, 8'h40, 0);
    end
    // a second timer event mid conversion restarts it
    wr(12'h800, 8'hD0, 0);
    tmr <= 1;
    @(posedge aclk);
    tmr <= 0;
    repeat (5) @(posedge aclk);
    tmr <= 1;
    @(posedge aclk);
    tmr <= 0;
    wirq(10, g);
    chk(g, 0);
    wirq(10, g);
    chk(g, 1);
    $display("hardware trigger done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
